// >>> common/ssr_consts.vh
// Shared constants of the status reporting block: bit positions, reset values, selector codes.
// Functional notes
// - Condition bits mirror live state; reading them never clears anything.
// - Questionable event bit latches when a condition rises from 0 to 1 (standard event bits latch on level); repeats while set are ignored.
// - Event register clears on its event query and on clear-status, keeping only events that arrive in that same cycle.
// - Enable register is read/write and selects events feeding the group summary.
// - Clear-status clears all event bits, leaves every enable register alone.
// - Preset command clears every bit of the questionable enable register; standard event enable is left alone.
// - Message-available bit set while output data waits, cleared after all read.
// - Clearing a group event register clears only its summary bit.
// - Bit 2 error queue, bit 3 questionable, bit 5 standard event; 0,1,7 zero.
// - Bit 6 master summary set when any service-enabled status bit is set.
// - Clear-status clears the status summary byte condition bits.
// - Writing zero to the service-request enable mask clears it.
// - At power-on, service mask cleared only if power-on-clear flag is 1.
// - Service request line asserted when bit 6 rises from 0 to 1.
// - Serial poll clears poll bit 6 and releases the line, nothing else.
// - Serial poll answered at once by bus logic, independent of command flow.
// - Status byte query returns summary byte with master summary in bit 6, runs in order, never clears request.
// - Queries return and writes accept the binary-weighted sum of bits.
// - Questionable group summarises enabled events; its mask written by its command.
// - Operation-complete sets standard event bit 0, feeding status bit 5.
// - Questionable enable cleared at power-on always, by preset, by writing 0.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

`define SSR_QUES_W      16
`define SSR_STD_W       8
`define SSR_BYTE_W      8

`define SSR_STB_ERR     2
`define SSR_STB_QUES    3
`define SSR_STB_MAV     4
`define SSR_STB_ESB     5
`define SSR_STB_MSS     6
`define SSR_STD_OPC     0

`define SSR_SRE_RST     8'h00
`define SSR_ESE_RST     8'h00
`define SSR_QEN_RST     16'h0000
`define SSR_STB_RST     8'h00

`define SSR_QRY_QCOND   3'h0
`define SSR_QRY_QEVEN   3'h1
`define SSR_QRY_QENAB   3'h2
`define SSR_QRY_ESR     3'h3
`define SSR_QRY_ESE     3'h4
`define SSR_QRY_SRE     3'h5
`define SSR_QRY_STB     3'h6

`define SSR_WR_QENAB    2'h0
`define SSR_WR_ESE      2'h1
`define SSR_WR_SRE      2'h2

`endif

// >>> src/ssr_evt_group.v
// Condition, event and enable registers of one status group with its summary output.
`timescale 1ns/10ps
module ssr_evt_group #(
	parameter W    = 16,
	parameter EDGE = 1,
	parameter [W-1:0] EN_RST = {W{1'b0}}
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] set_in,
	input  wire         evt_clr,
	input  wire         en_clr,
	input  wire         en_wr,
	input  wire [W-1:0] en_data,
	output wire [W-1:0] cond_o,
	output reg  [W-1:0] evt_r,
	output reg  [W-1:0] en_r,
	output wire         summary
);
	reg  [W-1:0] prev_r;
	wire [W-1:0] hit;
	wire [W-1:0] evt_nxt;

	// Conditions pass straight through; nothing here latches them.
	assign cond_o  = set_in;
	assign hit     = (EDGE != 0) ? (set_in & ~prev_r) : set_in;
	// An event arriving with the clear is kept, so no occurrence is lost.
	assign evt_nxt = (evt_clr ? {W{1'b0}} : evt_r) | hit;
	assign summary = |(evt_r & en_r);

	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			prev_r <= {W{1'b0}};
			evt_r  <= {W{1'b0}};
			en_r   <= EN_RST;
		end
		else
		begin
			prev_r <= set_in;
			evt_r  <= evt_nxt;
			if (en_wr)
				en_r <= en_data;
			else if (en_clr)
				en_r <= {W{1'b0}};
		end
	end
endmodule // ssr_evt_group

// >>> src/ssr_srq_ctrl.v
// Request-service latch and open-drain service request pin drive.
`timescale 1ns/10ps
module ssr_srq_ctrl (
	input  wire clk,
	input  wire rst_b,
	input  wire mss,
	input  wire poll,
	output reg  rqs_r,
	output wire srq_out,
	output reg  srq_oe_b_r
);
	reg  mss_prev_r;
	wire rqs_nxt;

	// A new rising summary during a poll wins, so the request is not dropped.
	assign rqs_nxt = (mss & ~mss_prev_r) | (rqs_r & ~poll);
	assign srq_out = 1'b0;

	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			mss_prev_r <= 1'b0;
			rqs_r      <= 1'b0;
			srq_oe_b_r <= 1'b1;
		end
		else
		begin
			mss_prev_r <= mss;
			rqs_r      <= rqs_nxt;
			srq_oe_b_r <= ~rqs_nxt;
		end
	end
endmodule // ssr_srq_ctrl

// >>> src/ssr_status.v
// Top of the status reporting block: status byte, service mask, queries and serial poll.
`timescale 1ns/10ps
`include "ssr_consts.vh"
module ssr_status (
	input  wire                     clk,
	input  wire                     rst_b,
	input  wire                     psc_flag,
	input  wire [`SSR_BYTE_W-1:0]   nv_sre,
	input  wire [`SSR_QUES_W-1:0]   ques_cond,
	input  wire [`SSR_STD_W-1:0]    std_evt_set,
	input  wire                     opc_done,
	input  wire                     err_queue_nonempty,
	input  wire                     obuf_nonempty,
	input  wire                     cmd_cls,
	input  wire                     cmd_pres,
	input  wire                     wr_req,
	input  wire [1:0]               wr_sel,
	input  wire [`SSR_QUES_W-1:0]   wr_data,
	input  wire                     qry_req,
	input  wire [2:0]               qry_sel,
	input  wire                     spoll_req,
	output reg                      rsp_valid_r,
	output reg  [`SSR_QUES_W-1:0]   rsp_data_r,
	output reg                      spoll_valid_r,
	output reg  [`SSR_BYTE_W-1:0]   spoll_data_r,
	output wire [`SSR_BYTE_W-1:0]   status_summary_byte,
	output wire [`SSR_BYTE_W-1:0]   sre_value,
	output wire                     srq_out,
	output wire                     srq_oe_b
);
	reg  [`SSR_BYTE_W-1:0]  stb_r;
	reg  [`SSR_BYTE_W-1:0]  stb_nxt;
	reg  [`SSR_BYTE_W-1:0]  sre_r;
	reg                     por_done_r;
	reg  [`SSR_QUES_W-1:0]  rsp_nxt;
	reg                     rsp_ok;

	wire                    wr_qen;
	wire                    wr_ese;
	wire                    wr_sre;
	wire                    rd_qeven;
	wire                    rd_esr;
	wire                    ques_clr;
	wire                    std_clr;
	wire [`SSR_QUES_W-1:0]  q_cond;
	wire [`SSR_QUES_W-1:0]  q_evt;
	wire [`SSR_QUES_W-1:0]  q_en;
	wire                    q_sum;
	wire [`SSR_STD_W-1:0]   s_set;
	wire [`SSR_STD_W-1:0]   s_evt;
	wire [`SSR_STD_W-1:0]   s_en;
	wire                    s_sum;
	wire                    mav;
	wire                    mss;
	wire                    rqs;
	wire [`SSR_BYTE_W-1:0]  stb_view;
	wire [`SSR_BYTE_W-1:0]  poll_view;

	// Widens a byte to the response width so every query shares one data path.
	function [`SSR_QUES_W-1:0] ssr_widen;
		input [`SSR_BYTE_W-1:0] b;
		begin
			ssr_widen = {{(`SSR_QUES_W-`SSR_BYTE_W){1'b0}}, b};
		end
	endfunction

	// Places bit 6 into a status byte whose other bits come from the summary register.
	function [`SSR_BYTE_W-1:0] ssr_with_b6;
		input [`SSR_BYTE_W-1:0] b;
		input                   b6;
		begin
			ssr_with_b6 = b;
			ssr_with_b6[`SSR_STB_MSS] = b6;
		end
	endfunction

	assign wr_qen   = wr_req && (wr_sel == `SSR_WR_QENAB);
	assign wr_ese   = wr_req && (wr_sel == `SSR_WR_ESE);
	assign wr_sre   = wr_req && (wr_sel == `SSR_WR_SRE);
	assign rd_qeven = qry_req && (qry_sel == `SSR_QRY_QEVEN);
	assign rd_esr   = qry_req && (qry_sel == `SSR_QRY_ESR);

	// An event query hands out the old value and empties the register at the same edge.
	assign ques_clr = cmd_cls | rd_qeven;
	assign std_clr  = cmd_cls | rd_esr;

	// Operation complete is a pulse, so this group latches levels without edge detection.
	assign s_set = std_evt_set | {{(`SSR_STD_W-1){1'b0}}, opc_done};

	ssr_evt_group #(
		.W      (`SSR_QUES_W),
		.EDGE   (1),
		.EN_RST (`SSR_QEN_RST)
	) u_ques (
		.clk     (clk),
		.rst_b   (rst_b),
		.set_in  (ques_cond),
		.evt_clr (ques_clr),
		.en_clr  (cmd_pres),
		.en_wr   (wr_qen),
		.en_data (wr_data),
		.cond_o  (q_cond),
		.evt_r   (q_evt),
		.en_r    (q_en),
		.summary (q_sum)
	);

	ssr_evt_group #(
		.W      (`SSR_STD_W),
		.EDGE   (0),
		.EN_RST (`SSR_ESE_RST)
	) u_std (
		.clk     (clk),
		.rst_b   (rst_b),
		.set_in  (s_set),
		.evt_clr (std_clr),
		.en_clr  (1'b0),
		.en_wr   (wr_ese),
		.en_data (wr_data[`SSR_STD_W-1:0]),
		.cond_o  (),
		.evt_r   (s_evt),
		.en_r    (s_en),
		.summary (s_sum)
	);

	// A response still sitting in our own register counts as waiting output.
	assign mav = obuf_nonempty | rsp_valid_r;

	always @*
	begin
		stb_nxt = `SSR_STB_RST;
		stb_nxt[`SSR_STB_ERR]  = err_queue_nonempty;
		stb_nxt[`SSR_STB_QUES] = q_sum & ~ques_clr;
		stb_nxt[`SSR_STB_MAV]  = mav;
		stb_nxt[`SSR_STB_ESB]  = s_sum & ~std_clr;
		if (cmd_cls)
			stb_nxt = `SSR_STB_RST;
	end

	always @(posedge clk)
	begin
		if (!rst_b)
			stb_r <= `SSR_STB_RST;
		else
			stb_r <= stb_nxt;
	end

	// Bit 6 of the mask is ignored because the summary cannot enable itself.
	assign mss = |(stb_r & sre_r & ~(8'h01 << `SSR_STB_MSS));

	assign stb_view            = ssr_with_b6(stb_r, mss);
	assign poll_view           = ssr_with_b6(stb_r, rqs);
	assign status_summary_byte = stb_view;
	assign sre_value           = sre_r;

	// Reset leaves a known mask; the first cycle after release decides whether to restore it.
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			sre_r      <= `SSR_SRE_RST;
			por_done_r <= 1'b0;
		end
		else if (!por_done_r)
		begin
			por_done_r <= 1'b1;
			if (psc_flag)
				sre_r <= `SSR_SRE_RST;
			else
				sre_r <= nv_sre;
		end
		else if (wr_sre)
			sre_r <= wr_data[`SSR_BYTE_W-1:0];
	end

	always @*
	begin
		rsp_nxt = {`SSR_QUES_W{1'b0}};
		rsp_ok  = 1'b1;
		case (qry_sel)
			`SSR_QRY_QCOND: rsp_nxt = q_cond;
			`SSR_QRY_QEVEN: rsp_nxt = q_evt;
			`SSR_QRY_QENAB: rsp_nxt = q_en;
			`SSR_QRY_ESR:   rsp_nxt = ssr_widen(s_evt);
			`SSR_QRY_ESE:   rsp_nxt = ssr_widen(s_en);
			`SSR_QRY_SRE:   rsp_nxt = ssr_widen(sre_r);
			`SSR_QRY_STB:   rsp_nxt = ssr_widen(stb_view);
			default:        rsp_ok  = 1'b0;
		endcase
	end

	// Queries come in command order on this port, so the status byte query
	// naturally follows every earlier command and leaves the request latch alone.
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= {`SSR_QUES_W{1'b0}};
		end
		else
		begin
			rsp_valid_r <= qry_req & rsp_ok;
			if (qry_req)
				rsp_data_r <= rsp_nxt;
		end
	end

	// The poll path bypasses the command port entirely, so it may trail recent commands.
	always @(posedge clk)
	begin
		if (!rst_b)
		begin
			spoll_valid_r <= 1'b0;
			spoll_data_r  <= `SSR_STB_RST;
		end
		else
		begin
			spoll_valid_r <= spoll_req;
			if (spoll_req)
				spoll_data_r <= poll_view;
		end
	end

	ssr_srq_ctrl u_srq (
		.clk        (clk),
		.rst_b      (rst_b),
		.mss        (mss),
		.poll       (spoll_req),
		.rqs_r      (rqs),
		.srq_out    (srq_out),
		.srq_oe_b_r (srq_oe_b)
	);
endmodule // ssr_status

// >>> testbench/ssr_host_model.sv
// Host-side model of the open-drain service request line.
`timescale 1ns/10ps
module ssr_host_model (
	input  wire    srq_out,
	input  wire    srq_oe_b,
	output wire    srq_line,
	output integer srq_seen
);
	// Nobody pulling leaves the bus pull-up in charge, so the idle level is high.
	assign srq_line = srq_oe_b ? 1'b1 : srq_out;
	initial srq_seen = 0;
	always @(negedge srq_line) srq_seen = srq_seen + 1;
endmodule // ssr_host_model

// >>> testbench/ssr_status_chk.sv
// Port-level assertions for the status reporting block.
`timescale 1ns/10ps
`include "ssr_consts.vh"
module ssr_status_chk (
	input wire                   clk,
	input wire                   rst_b,
	input wire [`SSR_QUES_W-1:0] ques_cond,
	input wire                   obuf_nonempty,
	input wire                   cmd_cls,
	input wire                   qry_req,
	input wire [2:0]             qry_sel,
	input wire                   spoll_req,
	input wire                   rsp_valid_r,
	input wire [`SSR_QUES_W-1:0] rsp_data_r,
	input wire                   spoll_valid_r,
	input wire [`SSR_BYTE_W-1:0] spoll_data_r,
	input wire [`SSR_BYTE_W-1:0] status_summary_byte,
	input wire [`SSR_BYTE_W-1:0] sre_value,
	input wire                   srq_out,
	input wire                   srq_oe_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire [7:0] sb = status_summary_byte;
	property p_valid; rsp_valid_r == $past(qry_req && qry_sel != 3'h7); endproperty
	a_valid: assert property (p_valid) else $error("query answer timing wrong");
	property p_cond; qry_req && qry_sel == 3'h0 |=> rsp_data_r == $past(ques_cond); endproperty
	a_cond: assert property (p_cond) else $error("condition read wrong");
	property p_stbq; qry_req && qry_sel == 3'h6 |=> rsp_data_r[7:0] == $past(sb); endproperty
	a_stbq: assert property (p_stbq) else $error("status query value wrong");
	property p_stb_srq;
		qry_req && qry_sel == 3'h6 && !spoll_req && !cmd_cls && !srq_oe_b |=> !srq_oe_b;
	endproperty
	a_stb_srq: assert property (p_stb_srq) else $error("status query released line");
	property p_poll; spoll_req |=> spoll_valid_r && spoll_data_r[5:0] == $past(sb[5:0]); endproperty
	a_poll: assert property (p_poll) else $error("poll answer wrong");
	property p_poll_rel; spoll_req && !$rose(sb[6]) |=> srq_oe_b; endproperty
	a_poll_rel: assert property (p_poll_rel) else $error("poll kept line");
	property p_srq; $rose(sb[6]) |=> !srq_oe_b && !srq_out; endproperty
	a_srq: assert property (p_srq) else $error("no service request");
	property p_mss; sb[6] == |(sb[5:0] & sre_value[5:0]); endproperty
	a_mss: assert property (p_mss) else $error("master summary wrong");
	property p_zero; !(sb[7] || sb[1] || sb[0]); endproperty
	a_zero: assert property (p_zero) else $error("unused bit set");
	property p_cls; cmd_cls |=> sb == 8'h00; endproperty
	a_cls: assert property (p_cls) else $error("clear left status");
	property p_mav; $past(rst_b) && $past(obuf_nonempty) && !$past(cmd_cls) |-> sb[4]; endproperty
	a_mav: assert property (p_mav) else $error("message bit missing");
	c_srq: cover property ($fell(srq_oe_b));
	c_poll: cover property (spoll_req ##1 spoll_valid_r);
	c_cls: cover property (cmd_cls);
endmodule // ssr_status_chk
bind ssr_status ssr_status_chk u_chk (.clk(clk), .rst_b(rst_b), .ques_cond(ques_cond),
	.obuf_nonempty(obuf_nonempty), .cmd_cls(cmd_cls), .qry_req(qry_req), .qry_sel(qry_sel),
	.spoll_req(spoll_req), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
	.spoll_valid_r(spoll_valid_r), .spoll_data_r(spoll_data_r),
	.status_summary_byte(status_summary_byte), .sre_value(sre_value), .srq_out(srq_out),
	.srq_oe_b(srq_oe_b));

// >>> testbench/testbench.sv
// Self-checking bench for the status reporting block.
`timescale 1ns/10ps
module testbench;
	reg         clk = 0;
	reg         rst_b = 0;
	reg         psc_flag = 1;
	reg  [15:0] ques_cond = 16'h0000;
	reg         err_q = 0;
	reg         obuf = 0;
	reg  [2:0]  cmd = 3'h0;
	reg         wr_req = 0;
	reg  [1:0]  wr_sel = 2'h0;
	reg  [15:0] wr_data = 16'h0000;
	reg         qry_req = 0;
	reg  [2:0]  qry_sel = 3'h0;
	reg         spoll_req = 0;
	wire        rsp_valid_r, spoll_valid_r, srq_out, srq_oe_b, srq_line;
	wire [15:0] rsp_data_r;
	wire [7:0]  spoll_data_r, stb, sre_value;
	integer     srq_seen;
	integer     fail_count = 0;
	integer     tests_run = 0;
	integer     tn = 1;
	always #2 clk = ~clk;
	ssr_status dut (.clk(clk), .rst_b(rst_b), .psc_flag(psc_flag), .nv_sre(8'h24),
		.ques_cond(ques_cond), .std_evt_set(8'h00), .opc_done(cmd[0]), .cmd_cls(cmd[1]),
		.cmd_pres(cmd[2]), .err_queue_nonempty(err_q), .obuf_nonempty(obuf),
		.wr_req(wr_req), .wr_sel(wr_sel), .wr_data(wr_data), .qry_req(qry_req),
		.qry_sel(qry_sel), .spoll_req(spoll_req), .rsp_valid_r(rsp_valid_r),
		.rsp_data_r(rsp_data_r), .spoll_valid_r(spoll_valid_r), .spoll_data_r(spoll_data_r),
		.status_summary_byte(stb), .sre_value(sre_value), .srq_out(srq_out),
		.srq_oe_b(srq_oe_b));
	ssr_host_model host (.srq_out(srq_out), .srq_oe_b(srq_oe_b), .srq_line(srq_line),
		.srq_seen(srq_seen));
	task chk(input [15:0] got, input [15:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// Bit 4 follows query traffic, so status compares mask it and test it on its own.
	task sb(input [7:0] e);
		chk({8'h00, stb & 8'hEF}, {8'h00, e});
	endtask
	task wr(input [1:0] s, input [15:0] d);
	begin
		@(posedge clk) {wr_req, wr_sel, wr_data} <= {1'b1, s, d};
		@(posedge clk) wr_req <= 1'b0;
		#1;
	end
	endtask
	task qry(input [2:0] s, input [15:0] e);
	begin
		@(posedge clk) {qry_req, qry_sel} <= {1'b1, s};
		@(posedge clk) qry_req <= 1'b0;
		#1 chk({15'h0000, rsp_valid_r}, 16'h0001);
		chk(rsp_data_r & ((s == 3'h6) ? 16'hFFEF : 16'hFFFF), e);
	end
	endtask
	task poll(input [7:0] e);
	begin
		@(posedge clk) spoll_req <= 1'b1;
		@(posedge clk) spoll_req <= 1'b0;
		#1 chk({8'h00, spoll_data_r & 8'hEF}, {8'h00, e});
		chk({15'h0000, spoll_valid_r}, 16'h0001);
	end
	endtask
	task pl(input [2:0] m);
	begin
		@(posedge clk) cmd <= m;
		@(posedge clk) cmd <= 3'h0;
		#1;
	end
	endtask
	task st;
	begin
		repeat (4) @(posedge clk);
		#1;
	end
	endtask
	task rst(input p);
	begin
		@(posedge clk) {rst_b, psc_flag} <= {1'b0, p};
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		#1;
	end
	endtask
	task tend;
	begin
		$display("test %0d done", tn);
		tn = tn + 1;
	end
	endtask
	task test_done;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		#20000;
		fail_count = fail_count + 1;
		test_done;
	end
	initial
	begin
		rst(1'b1);
		chk({8'h00, sre_value}, 16'h0000);
		qry(3'h2, 16'h0000);
		tend;
		@(posedge clk) ques_cond <= 16'h0201;
		st;
		qry(3'h0, 16'h0201);
		qry(3'h0, 16'h0201);
		qry(3'h1, 16'h0201);
		qry(3'h1, 16'h0000);
		wr(2'h0, 16'h0020);
		qry(3'h2, 16'h0020);
		@(posedge clk) ques_cond <= 16'h0221;
		st;
		sb(8'h08);
		wr(2'h2, 16'h0008);
		st;
		chk({15'h0000, srq_oe_b}, 16'h0000);
		chk(srq_seen[15:0], 16'h0001);
		qry(3'h6, 16'h0048);
		chk({15'h0000, srq_oe_b}, 16'h0000);
		poll(8'h48);
		chk({15'h0000, srq_oe_b}, 16'h0001);
		sb(8'h48);
		poll(8'h08);
		qry(3'h1, 16'h0020);
		st;
		sb(8'h00);
		tend;
		pl(3'h2);
		wr(2'h1, 16'h0001);
		qry(3'h4, 16'h0001);
		wr(2'h2, 16'h0020);
		qry(3'h5, 16'h0020);
		pl(3'h1);
		st;
		sb(8'h60);
		chk(srq_seen[15:0], 16'h0002);
		qry(3'h3, 16'h0001);
		st;
		sb(8'h00);
		tend;
		@(posedge clk) ques_cond <= 16'h0201;
		@(posedge clk) ques_cond <= 16'h0221;
		pl(3'h1);
		st;
		sb(8'h68);
		pl(3'h2);
		sb(8'h00);
		st;
		qry(3'h1, 16'h0000);
		qry(3'h3, 16'h0000);
		qry(3'h4, 16'h0001);
		qry(3'h2, 16'h0020);
		pl(3'h4);
		qry(3'h2, 16'h0000);
		qry(3'h4, 16'h0001);
		wr(2'h2, 16'h0000);
		chk({8'h00, sre_value}, 16'h0000);
		wr(2'h0, 16'h0020);
		wr(2'h0, 16'h0000);
		qry(3'h2, 16'h0000);
		wr(2'h3, 16'h00FF);
		qry(3'h4, 16'h0001);
		@(posedge clk) {qry_req, qry_sel} <= {1'b1, 3'h7};
		@(posedge clk) qry_req <= 1'b0;
		#1 chk({15'h0000, rsp_valid_r}, 16'h0000);
		tend;
		@(posedge clk) obuf <= 1'b1;
		st;
		chk({15'h0000, stb[4]}, 16'h0001);
		@(posedge clk) obuf <= 1'b0;
		st;
		chk({15'h0000, stb[4]}, 16'h0000);
		@(posedge clk) err_q <= 1'b1;
		st;
		sb(8'h04);
		@(posedge clk) err_q <= 1'b0;
		wr(2'h0, 16'h0020);
		rst(1'b0);
		chk({8'h00, sre_value}, 16'h0024);
		qry(3'h2, 16'h0000);
		tend;
		test_done;
	end
endmodule // testbench
